// >>> pmi_pkg.sv
`default_nettype none
package pmi_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_PROX_CTRL  = 8'h81;
  localparam logic [7:0] ADDR_EMIT_PULSE = 8'h82;
  localparam logic [7:0] ADDR_PULSE_AVG  = 8'h83;
  localparam logic [7:0] ADDR_MEAS_INT   = 8'h84;
  localparam logic [7:0] ADDR_STATUS     = 8'h91;
  localparam logic [7:0] ADDR_DATA_LO    = 8'h92;
  localparam logic [7:0] ADDR_DATA_HI    = 8'h93;
  localparam logic [7:0] ADDR_INT_CFG    = 8'h98;
  localparam logic [7:0] ADDR_PERSIST    = 8'h99;
  localparam logic [7:0] ADDR_UPPER_LO   = 8'h9a;
  localparam logic [7:0] ADDR_UPPER_HI   = 8'h9b;
  localparam logic [7:0] ADDR_LOWER_LO   = 8'h9c;
  localparam logic [7:0] ADDR_LOWER_HI   = 8'h9d;
  localparam logic [7:0] ADDR_OFFS_LO    = 8'h9e;
  localparam logic [7:0] ADDR_OFFS_HI    = 8'h9f;
  localparam logic [7:0] ADDR_EMIT_CUR   = 8'ha4;
  localparam logic [7:0] ADDR_GLOBAL     = 8'had;
  localparam logic [7:0] ADDR_SIG_COND   = 8'hb7;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_PROX_CTRL  = 8'h10;
  localparam logic [7:0]  RST_EMIT_PULSE = 8'h7a;
  localparam logic [7:0]  RST_PULSE_AVG  = 8'h00;
  localparam logic [7:0]  RST_MEAS_INT   = 8'h04;
  localparam logic [7:0]  RST_INT_CFG    = 8'h08;
  localparam logic [7:0]  RST_PERSIST    = 8'h00;
  localparam logic [15:0] RST_UPPER      = 16'hffff;
  localparam logic [15:0] RST_LOWER      = 16'h0000;
  localparam logic [15:0] RST_OFFS       = 16'h0000;
  localparam logic [7:0]  RST_EMIT_CUR   = 8'h00;
  localparam logic [7:0]  RST_GLOBAL     = 8'h00;
  localparam logic [7:0]  RST_SIG_COND   = 8'h00;

  // ==========================================================
  // Field positions
  localparam int CTRL_SRST_BIT   = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int CTRL_LOGIC_BIT  = 2;
  localparam int CTRL_OFFS_BIT   = 3;
  localparam int INT_POL_BIT     = 2;

  // ==========================================================
  // Timing
  localparam int CLK_NS        = 10;
  localparam int PULSE_NS      = 32000;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int INTERVAL0_NS  = 6125000;
  localparam int INTERVAL1_NS  = 12500000;
  localparam int INTERVAL0_CYC = INTERVAL0_NS / CLK_NS;
  localparam int INTERVAL1_CYC = INTERVAL1_NS / CLK_NS;

  // ==========================================================
  // State encodings
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_ACKA = 3'b010,
    I_WR   = 3'b011,
    I_ACKW = 3'b100,
    I_RD   = 3'b101,
    I_ACKR = 3'b110
  } pmi_i2c_e;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_PULSE = 2'b01,
    M_GAP   = 2'b10
  } pmi_meas_e;

endpackage
`default_nettype wire

// >>> pmi_prox_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pmi_prox_ctrl #(
  parameter logic [6:0]  TARGET_ADDR   = 7'h23,
  parameter int unsigned INTERVAL0_CYC = pmi_pkg::INTERVAL0_CYC,
  parameter int unsigned INTERVAL1_CYC = pmi_pkg::INTERVAL1_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // I2C target pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // Interrupt pin
  output logic             int_o,
  output logic             int_oe_n_o,
  // Front end
  input  wire logic [15:0] adc_data_i,
  output logic             emitter_on_o
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  wire scl_s    = scl_sync[1];
  wire sda_s    = sda_sync[1];
  wire start_c  = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c   = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;

  // ==========================================================
  // I2C target engine
  pmi_pkg::pmi_i2c_e ist;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic [2:0] bcnt;
  logic       full;
  logic       rnw;
  logic       have_ptr;
  logic       mack;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_stat;
  logic [7:0] rd_data;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist <= pmi_pkg::I_IDLE;
      {shreg, tx, ptr, wr_addr, wr_data} <= 40'h0;
      {bcnt, full, rnw, have_ptr, mack} <= 7'h0;
      {wr_stb, rd_stat, sda_o} <= 3'h0;
      sda_oe_n_o <= 1'b1;
    end else begin
      wr_stb  <= 1'b0;
      rd_stat <= 1'b0;
      if (start_c) begin
        ist        <= pmi_pkg::I_ADDR;
        {bcnt, full, have_ptr} <= 5'h0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_c) begin
        ist        <= pmi_pkg::I_IDLE;
        sda_oe_n_o <= 1'b1;
      end else if (scl_rise) begin
        if (ist == pmi_pkg::I_ADDR || ist == pmi_pkg::I_WR) begin
          shreg <= {shreg[6:0], sda_s};
        end
        if (ist == pmi_pkg::I_ADDR || ist == pmi_pkg::I_WR || ist == pmi_pkg::I_RD) begin
          bcnt <= bcnt + 3'h1;
          full <= (bcnt == 3'h7);
        end
        if (ist == pmi_pkg::I_ACKR) begin
          mack <= !sda_s;
        end
      end else if (scl_fall) begin
        unique case (ist)
          pmi_pkg::I_IDLE: begin
          end
          pmi_pkg::I_ADDR: if (full) begin
            full <= 1'b0;
            if (shreg[7:1] == TARGET_ADDR) begin
              ist        <= pmi_pkg::I_ACKA;
              rnw        <= shreg[0];
              sda_oe_n_o <= 1'b0;
            end else begin
              ist <= pmi_pkg::I_IDLE;
            end
          end
          pmi_pkg::I_ACKA, pmi_pkg::I_ACKR: begin
            if (ist == pmi_pkg::I_ACKA && !rnw) begin
              ist        <= pmi_pkg::I_WR;
              sda_oe_n_o <= 1'b1;
            end else if (ist == pmi_pkg::I_ACKR && !mack) begin
              ist        <= pmi_pkg::I_IDLE;
            end else begin
              // Byte is fetched at load time so read side effects hit once
              ist        <= pmi_pkg::I_RD;
              tx         <= rd_data;
              sda_oe_n_o <= rd_data[7];
              rd_stat    <= (ptr == pmi_pkg::ADDR_STATUS);
              ptr        <= ptr + 8'h1;
            end
          end
          pmi_pkg::I_WR: if (full) begin
            full       <= 1'b0;
            ist        <= pmi_pkg::I_ACKW;
            sda_oe_n_o <= 1'b0;
            if (have_ptr) begin
              wr_stb  <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h1;
            end else begin
              ptr      <= shreg;
              have_ptr <= 1'b1;
            end
          end
          pmi_pkg::I_ACKW: begin
            ist        <= pmi_pkg::I_WR;
            sda_oe_n_o <= 1'b1;
          end
          pmi_pkg::I_RD: begin
            if (full) begin
              full       <= 1'b0;
              ist        <= pmi_pkg::I_ACKR;
              sda_oe_n_o <= 1'b1;
            end else begin
              sda_oe_n_o <= tx[6];
              tx         <= {tx[6:0], 1'b0};
            end
          end
          default: ist <= pmi_pkg::I_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Register file
  logic [7:0]  prox_ctrl;
  logic [7:0]  emit_pulse;
  logic [7:0]  pulse_avg;
  logic [7:0]  meas_int;
  logic [7:0]  int_cfg;
  logic [7:0]  persist;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [15:0] offset;
  logic [7:0]  emit_cur;
  logic [7:0]  global_setup;
  logic [7:0]  sig_cond;
  logic        srst;
  logic [15:0] result;
  logic        int_flag;
  logic        new_flag;
  logic        to_near_flag;
  logic        to_far_flag;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      srst <= 1'b0;
    end else begin
      srst <= wr_stb && wr_addr == pmi_pkg::ADDR_PROX_CTRL && wr_data[pmi_pkg::CTRL_SRST_BIT];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i || srst) begin
      prox_ctrl    <= pmi_pkg::RST_PROX_CTRL;
      emit_pulse   <= pmi_pkg::RST_EMIT_PULSE;
      pulse_avg    <= pmi_pkg::RST_PULSE_AVG;
      meas_int     <= pmi_pkg::RST_MEAS_INT;
      int_cfg      <= pmi_pkg::RST_INT_CFG;
      persist      <= pmi_pkg::RST_PERSIST;
      upper_limit  <= pmi_pkg::RST_UPPER;
      lower_limit  <= pmi_pkg::RST_LOWER;
      offset       <= pmi_pkg::RST_OFFS;
      emit_cur     <= pmi_pkg::RST_EMIT_CUR;
      global_setup <= pmi_pkg::RST_GLOBAL;
      sig_cond     <= pmi_pkg::RST_SIG_COND;
    end else if (wr_stb) begin
      case (wr_addr)
        // Reset bit is self-clearing, never stored
        pmi_pkg::ADDR_PROX_CTRL:  prox_ctrl <= wr_data & 8'hfe;
        pmi_pkg::ADDR_EMIT_PULSE: emit_pulse <= wr_data;
        pmi_pkg::ADDR_PULSE_AVG:  pulse_avg <= wr_data;
        pmi_pkg::ADDR_MEAS_INT:   meas_int <= wr_data;
        pmi_pkg::ADDR_INT_CFG:    int_cfg <= wr_data;
        pmi_pkg::ADDR_PERSIST:    persist <= wr_data;
        pmi_pkg::ADDR_UPPER_LO:   upper_limit[7:0] <= wr_data;
        pmi_pkg::ADDR_UPPER_HI:   upper_limit[15:8] <= wr_data;
        pmi_pkg::ADDR_LOWER_LO:   lower_limit[7:0] <= wr_data;
        pmi_pkg::ADDR_LOWER_HI:   lower_limit[15:8] <= wr_data;
        pmi_pkg::ADDR_OFFS_LO:    offset[7:0] <= wr_data;
        pmi_pkg::ADDR_OFFS_HI:    offset[15:8] <= wr_data;
        pmi_pkg::ADDR_EMIT_CUR:   emit_cur <= wr_data;
        pmi_pkg::ADDR_GLOBAL:     global_setup <= wr_data;
        pmi_pkg::ADDR_SIG_COND:   sig_cond <= wr_data;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (ptr)
      pmi_pkg::ADDR_PROX_CTRL:  rd_data = prox_ctrl;
      pmi_pkg::ADDR_EMIT_PULSE: rd_data = emit_pulse;
      pmi_pkg::ADDR_PULSE_AVG:  rd_data = pulse_avg;
      pmi_pkg::ADDR_MEAS_INT:   rd_data = meas_int;
      pmi_pkg::ADDR_STATUS:     rd_data = {2'h0, to_near_flag, to_far_flag, 2'h0, int_flag, new_flag};
      pmi_pkg::ADDR_DATA_LO:    rd_data = result[7:0];
      pmi_pkg::ADDR_DATA_HI:    rd_data = result[15:8];
      pmi_pkg::ADDR_INT_CFG:    rd_data = int_cfg;
      pmi_pkg::ADDR_PERSIST:    rd_data = persist;
      pmi_pkg::ADDR_UPPER_LO:   rd_data = upper_limit[7:0];
      pmi_pkg::ADDR_UPPER_HI:   rd_data = upper_limit[15:8];
      pmi_pkg::ADDR_LOWER_LO:   rd_data = lower_limit[7:0];
      pmi_pkg::ADDR_LOWER_HI:   rd_data = lower_limit[15:8];
      pmi_pkg::ADDR_OFFS_LO:    rd_data = offset[7:0];
      pmi_pkg::ADDR_OFFS_HI:    rd_data = offset[15:8];
      pmi_pkg::ADDR_EMIT_CUR:   rd_data = emit_cur;
      pmi_pkg::ADDR_GLOBAL:     rd_data = global_setup;
      pmi_pkg::ADDR_SIG_COND:   rd_data = sig_cond;
      default:                  rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Measurement sequencer
  pmi_pkg::pmi_meas_e mst;
  logic [11:0] phase;
  logic [4:0]  pcnt;
  logic [4:0]  npulse_q;
  logic [2:0]  rcnt;
  logic [1:0]  avg_q;
  logic [18:0] sum;
  logic [26:0] timer;
  logic [26:0] interval;
  logic        result_stb;

  localparam logic [11:0] PULSE_LAST = 12'(pmi_pkg::PULSE_CYC - 1);

  wire         active   = prox_ctrl[pmi_pkg::CTRL_ACTIVE_BIT];
  wire         start_m  = active && mst == pmi_pkg::M_IDLE && timer == 27'h0;
  wire         gap_end  = mst == pmi_pkg::M_GAP && phase == PULSE_LAST;
  wire         rep_end  = gap_end && pcnt == npulse_q;
  wire         last_rep = rcnt == 3'((4'h1 << avg_q) - 4'h1);
  wire [18:0]  sum_tot  = sum + {3'h0, adc_data_i};
  wire [15:0]  avg_val  = 16'(sum_tot >> avg_q);
  wire         offs_en  = prox_ctrl[pmi_pkg::CTRL_OFFS_BIT];
  // Clamp at zero so crosstalk larger than signal cannot wrap to near
  wire [15:0]  res_val  = !offs_en ? avg_val :
                          (avg_val >= offset ? avg_val - offset : 16'h0);

  always_comb begin
    if (meas_int[2:0] == 3'h0) begin
      interval = 27'(INTERVAL0_CYC);
    end else begin
      interval = 27'(INTERVAL1_CYC) << (meas_int[2:0] - 3'h1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i || srst) begin
      timer <= 27'h0;
    end else if (!active) begin
      timer <= 27'h0;
    end else if (timer != 27'h0) begin
      timer <= timer - 27'h1;
    end else if (mst == pmi_pkg::M_IDLE) begin
      timer <= interval - 27'h1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i || srst) begin
      mst        <= pmi_pkg::M_IDLE;
      {phase, pcnt, npulse_q, rcnt, avg_q, sum} <= 46'h0;
      result     <= 16'h0;
      result_stb <= 1'b0;
    end else begin
      result_stb <= 1'b0;
      unique case (mst)
        pmi_pkg::M_IDLE: if (start_m) begin
          // Pulse count and averaging latched so a pulse_avg write mid-measurement cannot skew it
          mst      <= pmi_pkg::M_PULSE;
          {phase, pcnt, rcnt, sum} <= 39'h0;
          npulse_q <= pulse_avg[4:0];
          avg_q    <= pulse_avg[7:6];
        end
        pmi_pkg::M_PULSE: begin
          phase <= (phase == PULSE_LAST) ? 12'h0 : phase + 12'h1;
          if (phase == PULSE_LAST) begin
            mst <= pmi_pkg::M_GAP;
          end
        end
        pmi_pkg::M_GAP: begin
          phase <= (phase == PULSE_LAST) ? 12'h0 : phase + 12'h1;
          if (gap_end) begin
            mst  <= pmi_pkg::M_PULSE;
            pcnt <= pcnt + 5'h1;
          end
          if (rep_end) begin
            pcnt <= 5'h0;
            sum  <= sum_tot;
            rcnt <= rcnt + 3'h1;
            if (last_rep) begin
              mst        <= pmi_pkg::M_IDLE;
              result     <= res_val;
              result_stb <= 1'b1;
            end
          end
        end
        default: mst <= pmi_pkg::M_IDLE;
      endcase
      if (!active) begin
        // A result finishing as stand-by begins still loads result but raises no result_stb
        mst        <= pmi_pkg::M_IDLE;
        result_stb <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      emitter_on_o <= 1'b0;
    end else begin
      emitter_on_o <= mst == pmi_pkg::M_PULSE && active;
    end
  end

  // ==========================================================
  // Threshold, persistence and interrupt
  logic [3:0] pers_cnt;
  logic       near;

  wire        out_hi    = result > upper_limit;
  wire        out_lo    = result < lower_limit;
  wire [3:0]  need      = (persist[7:4] == 4'h0) ? 4'h1 : persist[7:4];
  wire [3:0]  next_pers = !(out_hi || out_lo) ? 4'h0 :
                          (pers_cnt == 4'hf ? pers_cnt : pers_cnt + 4'h1);
  wire        qual      = result_stb && next_pers >= need;
  wire        logic_t   = prox_ctrl[pmi_pkg::CTRL_LOGIC_BIT];
  wire        go_near   = qual && logic_t && out_hi && !near;
  wire        go_far    = qual && logic_t && out_lo && near;
  wire        set_int   = logic_t ? (go_near || go_far) : qual;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i || srst) begin
      {pers_cnt, near, int_flag, new_flag, to_near_flag, to_far_flag} <= 9'h0;
    end else begin
      if (result_stb) begin
        pers_cnt <= next_pers;
      end
      if (go_near) begin
        near <= 1'b1;
      end else if (go_far) begin
        near <= 1'b0;
      end
      // A new event beats a status read in the same cycle
      int_flag <= set_int || (int_flag && !rd_stat);
      new_flag <= result_stb || (new_flag && !rd_stat);
      to_near_flag <= go_near || (to_near_flag && !rd_stat);
      to_far_flag  <= go_far || (to_far_flag && !rd_stat);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_o      <= 1'b1;
      int_oe_n_o <= 1'b1;
    end else begin
      int_oe_n_o <= int_cfg[1:0] != 2'b01;
      int_o      <= int_cfg[pmi_pkg::INT_POL_BIT] ? int_flag : !int_flag;
    end
  end

  // ==========================================================
  // Checks
  logic [20:0] age;
  wire  [20:0] exp_cyc = 21'((32'd1 << avg_q) * (32'(npulse_q) + 32'd1) * 32'd2
                             * 32'(pmi_pkg::PULSE_CYC));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      age <= 21'h0;
    end else if (start_m) begin
      age <= 21'h0;
    end else if (mst != pmi_pkg::M_IDLE) begin
      age <= age + 21'h1;
    end
  end

  standby_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !active [*2] |-> !emitter_on_o && !result_stb)
    else $error("measurement activity in stand-by");

  soft_reset_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    srst |=> prox_ctrl == pmi_pkg::RST_PROX_CTRL && meas_int == pmi_pkg::RST_MEAS_INT
             && !int_flag && mst == pmi_pkg::M_IDLE)
    else $error("soft reset did not restore start-up state");

  meas_time_a: assert property (@(posedge core_clk_i) disable iff (rst_i || srst)
    result_stb |-> age == exp_cyc)
    else $error("measurement time differs from fixed figure");

  window_hit_a: assert property (@(posedge core_clk_i) disable iff (rst_i || srst)
    result_stb && !logic_t && persist[7:4] == 4'h0 && (out_hi || out_lo) |=> int_flag)
    else $error("out-of-window result did not flag interrupt");

  fresh_only_a: assert property (@(posedge core_clk_i) disable iff (rst_i || srst)
    $rose(int_flag) |-> $past(result_stb))
    else $error("interrupt raised without a new result");

  pin_disable_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    int_cfg[1:0] == 2'b00 |=> int_oe_n_o)
    else $error("interrupt pin driven while disabled");

  pin_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(int_flag) && int_cfg[pmi_pkg::INT_POL_BIT] && $stable(int_cfg) |=> int_o)
    else $error("interrupt pin not at active level");

  logic_type_a: assert property (@(posedge core_clk_i) disable iff (rst_i || srst)
    $rose(to_near_flag) || $rose(to_far_flag) |-> $past(logic_t))
    else $error("transition reported in window type");

  persist_need_a: assert property (@(posedge core_clk_i) disable iff (rst_i || srst)
    result_stb && !logic_t && (out_hi || out_lo) && next_pers < need && !int_flag
    |=> !int_flag)
    else $error("interrupt before persistence count reached");

  status_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rd_stat && !set_int |=> !int_flag)
    else $error("status read did not clear interrupt");

  offset_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i || srst)
    rep_end && last_rep && !offs_en |=> result == $past(avg_val))
    else $error("offset applied while disabled");

endmodule
`default_nettype wire

// >>> pmi_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmi_host (
  // Clock
  input  wire logic clk_i,
  // Bus wires
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  // ==========================================================
  // Bit level
  initial begin
    scl_o      = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // Target needs each SCL level longer than 3 cycles
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // Data moves only a half bit after SCL falls, never beside an SCL edge
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n_o <= b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
    half();
  endtask
  // Start when s is 1, stop when s is 0
  task automatic frame(input logic s);
    sda_oe_n_o <= s;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_n_o <= ~s;
    half();
    scl_o <= ~s;
    half();
  endtask
  // ==========================================================
  // Byte level; ninth bit released: target ACK, or host NACK on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, inout logic nak);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    nak = nak | a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    nak = 1'b0;
    frame(1'b1);
    xfer(8'h46, q, nak);
    xfer(a, q, nak);
    xfer(d, q, nak);
    frame(1'b0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic       last;
    nak  = 1'b0;
    last = 1'b0;
    frame(1'b1);
    xfer(8'h46, q, nak);
    xfer(a, q, nak);
    frame(1'b1);
    xfer(8'h47, q, nak);
    xfer(8'hff, d, last);
    frame(1'b0);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk_i;
  logic        rst_i;
  logic [15:0] adc;
  logic        scl;
  logic        sda_oe_n;
  logic        sda_o;
  logic        dut_oe_n;
  logic        int_o;
  logic        int_oe_n;
  logic        emit;
  wire logic   sda = sda_oe_n & dut_oe_n;
  int          err_count = 0;
  int          checked = 0;
  logic [7:0]  ra [11] = '{8'h82, 8'h83, 8'h84, 8'h98, 8'h99, 8'h9b, 8'h9c, 8'had, 8'ha4,
                           8'hb7, 8'h80};
  logic [7:0]  rv [11] = '{8'h7a, 8'h00, 8'h04, 8'h08, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00};

  pmi_prox_ctrl #(.INTERVAL0_CYC(200), .INTERVAL1_CYC(400)) u_pmi_prox_ctrl (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(dut_oe_n), .int_o(int_o), .int_oe_n_o(int_oe_n), .adc_data_i(adc),
    .emitter_on_o(emit));
  pmi_host u_pmi_host (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(sda_oe_n));

  // ==========================================================
  // Checking
  task automatic chk(input string n, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nak;
    u_pmi_host.wr(a, d, nak);
    chk("write ack", 16'h0, {15'h0, nak});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       nak;
    u_pmi_host.rd(a, q, nak);
    chk("read ack", 16'h0, {15'h0, nak});
    chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, q});
  endtask
  // Bounded: a missing pulse shows as width zero; one already running is skipped
  task automatic pulse(input logic [15:0] exp);
    int n = 0;
    for (int i = 0; i < 3500 && emit === 1'b1; i++)
      @(posedge core_clk_i);
    for (int i = 0; i < 3500 && emit !== 1'b1; i++)
      @(posedge core_clk_i);
    while (emit === 1'b1 && n < 4000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("pulse width", exp, 16'(n));
  endtask
  task automatic settle();
    repeat (6600) @(posedge core_clk_i);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (95000) @(posedge core_clk_i);
    err_count++;
    conclude();
  end
  initial begin
    rst_i = 1'b1;
    adc   = 16'd300;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    for (int i = 0; i < 11; i++)
      rc(ra[i], rv[i]);
    for (int i = 3; i >= 0; i--) begin
      wr(8'h83, 8'(i << 6));
      rc(8'h83, 8'(i << 6));
    end
    for (int i = 7; i >= 0; i--) begin
      wr(8'h84, 8'(i));
      rc(8'h84, 8'(i));
    end
    wr(8'had, 8'h18);
    wr(8'ha4, 8'h04);
    wr(8'hb7, 8'h10);
    wr(8'h9a, 8'he8);
    wr(8'h9b, 8'h03);
    wr(8'h9c, 8'hc8);
    wr(8'h9d, 8'h00);
    wr(8'h98, 8'h89);
    chk("int enable", 16'h0, {15'h0, int_oe_n});
    chk("int idle low pol", 16'h1, {15'h0, int_o});
    wr(8'h98, 8'h8d);
    chk("int idle high pol", 16'h0, {15'h0, int_o});
    pulse(16'd0);
    wr(8'h81, 8'h12);
    pulse(16'd3200);
    settle();
    rc(8'h92, 8'h2c);
    rc(8'h93, 8'h01);
    rc(8'h91, 8'h01);
    chk("int in window", 16'h0, {15'h0, int_o});
    adc <= 16'd1500;
    settle();
    chk("int above upper", 16'h1, {15'h0, int_o});
    adc <= 16'd300;
    settle();
    rc(8'h91, 8'h03);
    chk("int cleared", 16'h0, {15'h0, int_o});
    wr(8'h9e, 8'hc8);
    wr(8'h9f, 8'h00);
    wr(8'h81, 8'h1a);
    settle();
    rc(8'h92, 8'h64);
    chk("int below lower", 16'h1, {15'h0, int_o});
    // Three consecutive out-of-range results needed; one is already counted
    wr(8'h99, 8'h30);
    adc <= 16'd1500;
    rc(8'h91, 8'h03);
    settle();
    rc(8'h91, 8'h01);
    chk("int held by persistence", 16'h0, {15'h0, int_o});
    wr(8'h81, 8'h1e);
    settle();
    chk("int on crossing", 16'h1, {15'h0, int_o});
    rc(8'h91, 8'h23);
    chk("sda drive level", 16'h0, {15'h0, sda_o});
    wr(8'h84, 8'h05);
    wr(8'h81, 8'h01);
    rc(8'h81, 8'h10);
    rc(8'h84, 8'h04);
    rc(8'h98, 8'h08);
    rc(8'h91, 8'h00);
    chk("int pin released", 16'h1, {15'h0, int_oe_n});
    pulse(16'd0);
    conclude();
  end
endmodule
`default_nettype wire
